// ==== hw/uoes_pkg.sv ====
// Package: register offsets, field positions and sizes for the OUT endpoint status block
package uoes_pkg;
	// Register widths and count slot number
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int CNT_W = 10;
	localparam int SLOTS = 2;
	// Register indexes on the plain register port
	localparam logic [2:0] REG_CTRL_LO = 3'h0;
	localparam logic [2:0] REG_CTRL_HI = 3'h1;
	localparam logic [2:0] REG_CNT_LO = 3'h2;
	localparam logic [2:0] REG_CNT_HI = 3'h3;
	localparam logic [2:0] REG_IRQ_STAT = 3'h4;
	localparam logic [2:0] REG_IRQ_MASK = 3'h5;
	// Control low byte fields
	localparam int BIT_PKT_RDY = 0;
	localparam int BIT_FIFO_FULL = 1;
	localparam int BIT_OVERRUN = 2;
	localparam int BIT_DATA_ERR = 3;
	localparam int BIT_FLUSH = 4;
	// Control high byte fields
	localparam int BIT_ISO = 6;
	localparam int BIT_DBL_BUF = 7;
	// Interrupt status fields
	localparam int IRQ_PKT = 0;
	localparam int IRQ_OVR = 1;
	localparam int IRQ_ERR = 2;
	localparam int IRQ_W = 3;
	// Count high byte width
	localparam int CNT_HI_W = 2;
	// Reset values and packet occupancy levels
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [9:0] RST_CNT = 10'h000;
	localparam logic [1:0] RST_OCC = 2'h0;
	localparam logic [1:0] ONE_PKT = 2'h1;
	localparam logic [1:0] TWO_PKT = 2'h2;
endpackage

// ==== hw/uoes_occupancy.sv ====
// Packet occupancy counter and full detection for the OUT FIFO
`timescale 1ns/10ps
module uoes_occupancy (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Control
	input wire logic double_buffer_enable,
	input wire logic push,
	input wire logic pop,
	// Status
	output logic [1:0] occ,
	output logic full
);
	logic [1:0] occ_ff;
	logic [1:0] nxt_occ;

	// Next occupancy: pop and push may meet in one cycle
	always_comb begin
		nxt_occ = occ_ff;
		if (push && !pop) begin
			nxt_occ = occ_ff + uoes_pkg::ONE_PKT;
		end else if (pop && !push && occ_ff != uoes_pkg::RST_OCC) begin
			nxt_occ = occ_ff - uoes_pkg::ONE_PKT;
		end
	end

	// Occupancy register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			occ_ff <= uoes_pkg::RST_OCC;
		end else if (clk_en) begin
			occ_ff <= nxt_occ;
		end
	end

	assign occ = occ_ff;
	// Full at two packets when double buffered, else at one
	assign full = double_buffer_enable ? (occ_ff >= uoes_pkg::TWO_PKT)
		: (occ_ff >= uoes_pkg::ONE_PKT);
endmodule

// ==== hw/uoes_top.sv ====
// OUT endpoint status flags, counts and register port
// Operation
// - CRC or bit-stuff error on a received OUT packet sets data error flag, bit 3.
// - Data error clears when software clears the packet ready flag.
// - Data error is only meaningful in isochronous mode.
// - Packet arriving while FIFO full sets overrun flag, bit 2.
// - Overrun valid in iso mode, sticky until software clears, else zero.
// - Double buffered: FIFO full reported in bit 1 once two packets held.
// - Single buffered: FIFO full as soon as one packet held.
// - FIFO full bit reads one when full, zero otherwise.
// - Packet ready flag, bit 0, sets once a packet sits in the FIFO.
// - Flush resets FIFO pointer, clears packet ready, drops next packet; the code keeps packet ready set when the flush leaves one of two packets held.
// - Ten-bit byte count of last packet, valid while packet ready set; count read is of the packet next to be unloaded, the older of two held.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module uoes_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Packet engine side
	input wire logic rx_pkt_done,
	input wire logic rx_pkt_bad,
	input wire logic [9:0] rx_byte_count,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Status outputs
	output logic out_packet_ready_flag,
	output logic out_fifo_full_flag,
	output logic rx_overrun_flag,
	output logic rx_data_error_flag,
	output logic fifo_ptr_reset,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic pkt_rdy_ff;
	logic full_ff;
	logic ovr_ff;
	logic err_ff;
	logic ptr_rst_ff;
	logic irq_ff;
	logic iso_ff;
	logic dbl_ff;
	logic [7:0] rdata_ff;
	logic [9:0] cnt_ff [uoes_pkg::SLOTS];
	logic rd_slot_ff;
	logic wr_slot_ff;
	logic [2:0] irq_stat_ff;
	logic [2:0] irq_mask_ff;
	logic [1:0] occ;
	logic full_now;
	logic wr_lo;
	logic wr_hi;
	logic sw_clr_rdy;
	logic flush_req;
	logic pop;
	logic store;
	logic lost;
	logic [2:0] irq_evt;
	logic [7:0] nxt_rdata;
	logic [9:0] cur_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	assign wr_lo = reg_wr && reg_addr == uoes_pkg::REG_CTRL_LO;
	assign wr_hi = reg_wr && reg_addr == uoes_pkg::REG_CTRL_HI;
	// Firmware clears packet ready by writing zero to bit 0
	assign sw_clr_rdy = wr_lo && !reg_wdata[uoes_pkg::BIT_PKT_RDY] && pkt_rdy_ff;
	assign flush_req = wr_lo && reg_wdata[uoes_pkg::BIT_FLUSH] && pkt_rdy_ff;
	assign pop = sw_clr_rdy || flush_req;
	// A packet is stored only when room exists, otherwise it is lost
	assign store = rx_pkt_done && !full_now;
	assign lost = rx_pkt_done && full_now;
	assign cur_cnt = cnt_ff[rd_slot_ff];

	////////////////////////////////////////////////////////////////////////////////
	// Occupancy
	uoes_occupancy u_occ (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.double_buffer_enable(dbl_ff),
		.push(store),
		.pop(pop),
		.occ(occ),
		.full(full_now)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Configuration: double buffer enable and isochronous select
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dbl_ff <= 1'b0;
			iso_ff <= 1'b0;
		end else if (clk_en && wr_hi) begin
			dbl_ff <= reg_wdata[uoes_pkg::BIT_DBL_BUF];
			iso_ff <= reg_wdata[uoes_pkg::BIT_ISO];
		end
	end

	// Packet ready: set while any packet held, re-evaluated after pop
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pkt_rdy_ff <= 1'b0;
		end else if (clk_en) begin
			if (store) begin
				pkt_rdy_ff <= 1'b1;
			end else if (pop) begin
				pkt_rdy_ff <= (occ == uoes_pkg::TWO_PKT);
			end
		end
	end

	// Full flag mirrors occupancy one cycle later
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			full_ff <= 1'b0;
		end else if (clk_en) begin
			full_ff <= full_now;
		end
	end

	// Overrun: sticky in iso mode, set wins over software clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ovr_ff <= 1'b0;
		end else if (clk_en) begin
			if (lost && iso_ff) begin
				ovr_ff <= 1'b1;
			end else if (wr_lo && !reg_wdata[uoes_pkg::BIT_OVERRUN]) begin
				ovr_ff <= 1'b0;
			end
		end
	end

	// Data error: set by bad stored packet in iso mode, cleared with packet ready
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			err_ff <= 1'b0;
		end else if (clk_en) begin
			if (store && rx_pkt_bad && iso_ff) begin
				err_ff <= 1'b1;
			end else if (pop) begin
				err_ff <= 1'b0;
			end
		end
	end

	// Byte count slots, written at store and read at the unload slot
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wr_slot_ff <= 1'b0;
			rd_slot_ff <= 1'b0;
		end else if (clk_en) begin
			if (store && dbl_ff) begin
				wr_slot_ff <= !wr_slot_ff;
			end
			if (pop && dbl_ff) begin
				rd_slot_ff <= !rd_slot_ff;
			end
		end
	end

	generate
		for (genvar s = 0; s < uoes_pkg::SLOTS; s++) begin : g_cnt
			// Count storage for one packet slot
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					cnt_ff[s] <= uoes_pkg::RST_CNT;
				end else if (clk_en && store && wr_slot_ff == 1'(s)) begin
					cnt_ff[s] <= rx_byte_count;
				end
			end
		end
	endgenerate

	// Pointer reset pulse toward the FIFO storage on flush
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ptr_rst_ff <= 1'b0;
		end else if (clk_en) begin
			ptr_rst_ff <= flush_req;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupts: sticky events, write one to clear, set wins
	assign irq_evt[uoes_pkg::IRQ_PKT] = store;
	assign irq_evt[uoes_pkg::IRQ_OVR] = lost && iso_ff;
	assign irq_evt[uoes_pkg::IRQ_ERR] = store && rx_pkt_bad && iso_ff;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_stat_ff <= 3'h0;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == uoes_pkg::REG_IRQ_STAT) begin
				irq_stat_ff <= (irq_stat_ff & ~reg_wdata[uoes_pkg::IRQ_W-1:0]) | irq_evt;
			end else begin
				irq_stat_ff <= irq_stat_ff | irq_evt;
			end
		end
	end

	// Mask register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_mask_ff <= 3'h0;
		end else if (clk_en && reg_wr && reg_addr == uoes_pkg::REG_IRQ_MASK) begin
			irq_mask_ff <= reg_wdata[uoes_pkg::IRQ_W-1:0];
		end
	end

	// Level interrupt output
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_ff <= 1'b0;
		end else if (clk_en) begin
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; flush bit reads zero since the flush completes at once
	always_comb begin
		nxt_rdata = uoes_pkg::RST_BYTE;
		case (reg_addr)
			uoes_pkg::REG_CTRL_LO: begin
				nxt_rdata[uoes_pkg::BIT_PKT_RDY] = pkt_rdy_ff;
				nxt_rdata[uoes_pkg::BIT_FIFO_FULL] = full_ff;
				nxt_rdata[uoes_pkg::BIT_OVERRUN] = ovr_ff;
				nxt_rdata[uoes_pkg::BIT_DATA_ERR] = err_ff;
			end
			uoes_pkg::REG_CTRL_HI: begin
				nxt_rdata[uoes_pkg::BIT_DBL_BUF] = dbl_ff;
				nxt_rdata[uoes_pkg::BIT_ISO] = iso_ff;
			end
			uoes_pkg::REG_CNT_LO: begin
				nxt_rdata = cur_cnt[7:0];
			end
			uoes_pkg::REG_CNT_HI: begin
				nxt_rdata[uoes_pkg::CNT_HI_W-1:0] = cur_cnt[9:8];
			end
			uoes_pkg::REG_IRQ_STAT: begin
				nxt_rdata[uoes_pkg::IRQ_W-1:0] = irq_stat_ff;
			end
			uoes_pkg::REG_IRQ_MASK: begin
				nxt_rdata[uoes_pkg::IRQ_W-1:0] = irq_mask_ff;
			end
			default: begin
				nxt_rdata = uoes_pkg::RST_BYTE;
			end
		endcase
	end

	// Read data register, valid the cycle after the strobe only
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rdata_ff <= uoes_pkg::RST_BYTE;
		end else if (clk_en) begin
			rdata_ff <= reg_rd ? nxt_rdata : uoes_pkg::RST_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata = rdata_ff;
	assign out_packet_ready_flag = pkt_rdy_ff;
	assign out_fifo_full_flag = full_ff;
	assign rx_overrun_flag = ovr_ff;
	assign rx_data_error_flag = err_ff;
	assign fifo_ptr_reset = ptr_rst_ff;
	assign irq = irq_ff;
endmodule

// ==== test/uoes_host_model.sv ====
// Host side model that delivers OUT packets to the packet engine ports
`timescale 1ns/10ps
module uoes_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Requests from the bench
	input wire logic send,
	input wire logic send_bad,
	input wire logic [9:0] send_len,
	// Packet engine outputs
	output logic rx_pkt_done,
	output logic rx_pkt_bad,
	output logic [9:0] rx_byte_count
);
	// One-cycle completion; the count is scrambled when not qualified
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rx_pkt_done <= 1'b0;
			rx_pkt_bad <= 1'b0;
			rx_byte_count <= 10'h3FF;
		end else begin
			rx_pkt_done <= send;
			rx_pkt_bad <= send & send_bad;
			rx_byte_count <= send ? send_len : ~rx_byte_count;
		end
	end
endmodule

// ==== test/uoes_top_chk.sv ====
// Checker for the OUT endpoint status flags
`timescale 1ns/10ps
module uoes_top_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Causes
	input wire logic rx_pkt_done,
	input wire logic rx_pkt_bad,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	// Flags
	input wire logic out_packet_ready_flag,
	input wire logic out_fifo_full_flag,
	input wire logic rx_overrun_flag,
	input wire logic rx_data_error_flag,
	input wire logic fifo_ptr_reset
);
	logic iso_ff;
	logic dbl_ff;
	logic ctl_wr;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Shadow of the mode bits, since they are not at the ports
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			iso_ff <= 1'b0;
			dbl_ff <= 1'b0;
		end else if (clk_en && reg_wr && reg_addr == uoes_pkg::REG_CTRL_HI) begin
			iso_ff <= reg_wdata[uoes_pkg::BIT_ISO];
			dbl_ff <= reg_wdata[uoes_pkg::BIT_DBL_BUF];
		end
	end
	assign ctl_wr = clk_en && reg_wr && reg_addr == uoes_pkg::REG_CTRL_LO;
	// Packet into an empty FIFO, and a pop by software
	sequence s_fresh;
		clk_en && rx_pkt_done && !out_packet_ready_flag && !reg_wr;
	endsequence
	sequence s_pop;
		ctl_wr && !reg_wdata[0] && out_packet_ready_flag && !rx_pkt_done;
	endsequence
	a_ready_on_rx: assert property (clk_en && rx_pkt_done |=> out_packet_ready_flag)
		else $error("ready flag missing after packet");
	a_err_on_bad: assert property (s_fresh ##0 (rx_pkt_bad && iso_ff) |=> rx_data_error_flag)
		else $error("data error flag missing");
	a_err_bulk_low: assert property (!iso_ff && !rx_data_error_flag |=> !rx_data_error_flag)
		else $error("data error set outside iso");
	a_err_clear: assert property (s_pop |=> !rx_data_error_flag)
		else $error("data error kept after pop");
	a_ovr_on_full: assert property (clk_en && rx_pkt_done && out_fifo_full_flag && iso_ff
		&& !reg_wr && !$past(reg_wr) |=> rx_overrun_flag)
		else $error("overrun flag missing");
	a_ovr_clean: assert property (s_fresh ##0 !rx_overrun_flag |=> !rx_overrun_flag)
		else $error("overrun on stored packet");
	a_ovr_sticky: assert property (rx_overrun_flag && !(ctl_wr && !reg_wdata[2])
		|=> rx_overrun_flag)
		else $error("overrun flag dropped");
	a_full_single: assert property (s_fresh ##0 !dbl_ff |=> ##1 out_fifo_full_flag)
		else $error("full missing with one packet");
	a_half_double: assert property (s_fresh ##0 dbl_ff |=> ##1 !out_fifo_full_flag)
		else $error("full with one packet double buffered");
	a_full_drop: assert property (s_pop ##0 !dbl_ff |=> ##1 !out_fifo_full_flag)
		else $error("full kept after pop");
	a_flush_pulse: assert property (ctl_wr && reg_wdata[4] && out_packet_ready_flag
		|=> fifo_ptr_reset)
		else $error("flush pulse missing");
endmodule
bind uoes_top uoes_top_chk uoes_top_chk_i (.*);

// ==== test/tb.sv ====
// Self-checking bench for the OUT endpoint status block
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clk_en = 1'b1;
	logic send = 1'b0, send_bad = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [9:0] send_len = 10'h000, rx_byte_count, lfsr = 10'h006;
	logic rx_pkt_done, rx_pkt_bad, fifo_ptr_reset, irq;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, rv;
	logic out_packet_ready_flag, out_fifo_full_flag, rx_overrun_flag, rx_data_error_flag;
	int mismatches = 0, num_checks = 0;
	uoes_host_model uoes_host_model_i (.*);
	uoes_top uoes_top_i (.*);
	// Clock
	initial forever #4 clk = ~clk;
	function automatic logic [9:0] f_lfsr(input logic [9:0] l);
		return {l[8:0], l[9] ^ l[6]};
	endfunction
	// Expected control low byte from the four flags
	function automatic logic [7:0] st(input logic r, f, o, e);
		return {4'h0, e, o, f, r};
	endfunction
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rv = reg_rdata;
	endtask
	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		rd(a);
		chk("reg", {2'h0, e}, {2'h0, rv});
	endtask
	task automatic pkt(input logic bad, input logic [9:0] n);
		@(posedge clk);
		send <= 1'b1;
		send_bad <= bad;
		send_len <= n;
		@(posedge clk);
		send <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		give_verdict();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			rc(a[2:0], 8'h00);
		end
		wr(uoes_pkg::REG_IRQ_MASK, 8'h07);
		// Single buffered bulk packets of random size, none corrupted
		repeat (4) begin
			lfsr = f_lfsr(lfsr);
			pkt(lfsr[0], lfsr);
			rc(uoes_pkg::REG_CTRL_LO, st(1, 1, 0, 0));
			rc(uoes_pkg::REG_CNT_LO, lfsr[7:0]);
			rc(uoes_pkg::REG_CNT_HI, {6'h00, lfsr[9:8]});
			chk("irq", 10'h001, {9'h000, irq});
			wr(uoes_pkg::REG_IRQ_STAT, 8'h01);
			wr(uoes_pkg::REG_CTRL_LO, 8'h00);
			repeat (2) @(negedge clk);
			chk("flags", 10'h000, {5'h00, irq, out_packet_ready_flag, out_fifo_full_flag,
				rx_overrun_flag, rx_data_error_flag});
		end
		// Isochronous double buffered: error, full at two, overrun
		wr(uoes_pkg::REG_CTRL_HI, 8'hC0);
		pkt(1'b1, 10'h3FF);
		rc(uoes_pkg::REG_CTRL_LO, st(1, 0, 0, 1));
		pkt(1'b0, 10'h000);
		rc(uoes_pkg::REG_CTRL_LO, st(1, 1, 0, 1));
		pkt(1'b0, 10'h155);
		rc(uoes_pkg::REG_CTRL_LO, st(1, 1, 1, 1));
		// Count follows the packet next to be unloaded, the first one held
		rc(uoes_pkg::REG_CNT_LO, 8'hFF);
		rc(uoes_pkg::REG_IRQ_STAT, 8'h07);
		wr(uoes_pkg::REG_CTRL_LO, 8'h04);
		rc(uoes_pkg::REG_CTRL_LO, st(1, 0, 1, 0));
		wr(uoes_pkg::REG_CTRL_LO, 8'h00);
		rc(uoes_pkg::REG_CTRL_LO, st(0, 0, 0, 0));
		// Flush of a waiting packet
		pkt(1'b0, 10'h010);
		wr(uoes_pkg::REG_CTRL_LO, 8'h15);
		@(negedge clk);
		chk("flush", 10'h001, {9'h000, fifo_ptr_reset});
		rc(uoes_pkg::REG_CTRL_LO, st(0, 0, 0, 0));
		give_verdict();
	end
endmodule
